/* common/pstl_pkg.sv */
// Shared constants and carriers of the phase-selective trip logic
package pstl_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Mode and timer clear
  localparam logic [7:0] OFS_PULSE  = 8'h04;  // Minimum pulse, ms
  localparam logic [7:0] OFS_EVOLVE = 8'h08;  // Evolving fault time, ms
  localparam logic [7:0] OFS_STATUS = 8'h0C;  // Live trip outputs
  localparam logic [7:0] OFS_EVENT  = 8'h10;  // Sticky on/off events, write 1 to clear

  // Control field positions
  localparam int CTRL_MODE_LSB = 0;  // Two-bit mode field
  localparam int CTRL_TCLR_BIT = 2;  // Write 1: synchronous timer clear

  // Setting limits and reset values, in ms
  localparam logic [15:0] MS_MIN         = 16'h0032;  // 50 ms
  localparam logic [15:0] MS_MAX         = 16'hEA60;  // 60000 ms
  localparam logic [15:0] PULSE_RST      = 16'h0096;  // 150 ms
  localparam logic [15:0] EVOLVE_RST     = 16'h03E8;  // 1000 ms

  // Time base
  localparam int CLK_PERIOD_NS = 20;         // 50 MHz core clock
  localparam int TICK_TIME_NS  = 1000000;    // 1 ms tick
  localparam int TICK_CYCLES_DEF = TICK_TIME_NS / CLK_PERIOD_NS;

  // Operating modes
  typedef enum logic [1:0] {
    PSTL_MODE_OFF,
    PSTL_MODE_THREE_ONLY,
    PSTL_MODE_SINGLE_OR_THREE
  } pstl_mode_t;

  // Requests from the protection functions
  typedef struct packed {
    logic       block_in;
    logic       single_phase_req;
    logic       three_phase_req;
    logic       force_all_phases;
    logic [2:0] phase_req;  // {phase_c_req, phase_b_req, phase_a_req}
  } pstl_req_t;

  // Event bits: [3:0] on of a,b,c,general; [7:4] off of the same
  typedef struct packed {
    logic [3:0] off_evt;
    logic [3:0] on_evt;
  } pstl_evt_t;

endpackage

/* logic/pstl_trip_logic.sv */
// How it works
// - Hold any trip for minimum pulse time
// - Two faulted phases also trip third phase
// - Force input turns single trips three-phase
// - New phase during evolving time trips all
// - Mode is off, three-only or single/three
// - Off mode asserts no trip outputs
// - Block input holds all trips inactive
// - Three-phase request trips all three phases
// - Per-phase requests map to matching trip outputs
// - General trip follows any issued trip
// - Three-phase output when all phases trip
// - Report on and off trip transitions
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module pstl_trip_logic #(
  parameter int TICK_CYCLES = pstl_pkg::TICK_CYCLES_DEF  // Core clocks per ms
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire pstl_pkg::pstl_req_t req_in,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   phase_a_trip,
  output logic                   phase_b_trip,
  output logic                   phase_c_trip,
  output logic                   any_trip_out,
  output logic                   all_phases_trip_out,
  output pstl_pkg::pstl_evt_t    event_pulse
);
  import pstl_pkg::*;

  pstl_req_t   req_meta;      // First synchroniser stage
  pstl_req_t   req_s;         // Second stage, used by the logic
  pstl_mode_t  mode;          // Operating mode
  logic [15:0] pulse_ms;      // Minimum pulse setting
  logic [15:0] evolve_ms;     // Evolving fault setting
  logic        tclr;          // One-cycle timer clear
  logic [15:0] tick_cnt;      // Divider for the ms tick
  logic        tick;          // One-cycle ms enable
  logic [16:0] pulse_cnt;     // Remaining hold time, ms
  logic [16:0] evolve_cnt;    // Remaining evolving window, ms
  logic [2:0]  trip_q;        // Phase trips {c,b,a}
  logic [2:0]  next_trip;     // Next phase trips
  logic        kill;          // Off mode or blocked
  logic        want_all;      // Three-phase decision
  logic [2:0]  want;          // Requested phases this cycle
  pstl_evt_t   evt_q;         // Sticky event register
  pstl_evt_t   evt_set;       // Events raised this cycle
  logic        acc;           // APB access phase
  logic        setup;         // APB setup phase
  logic [31:0] rd_mux;        // Read value for the setup address
  logic        addr_ok;       // Address is mapped

  // Clamp a written setting into its legal range
  function automatic logic [15:0] clamp_ms(input logic [31:0] v);
    if (v < {16'h0000, MS_MIN}) begin
      return MS_MIN;
    end else if (v > {16'h0000, MS_MAX}) begin
      return MS_MAX;
    end
    return v[15:0];
  endfunction

  // Two-flop synchroniser for the request pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_meta <= '0;
      req_s    <= '0;
    end else begin
      req_meta <= req_in;
      req_s    <= req_meta;
    end
  end

  // APB phase decode
  assign setup = psel && !penable;
  assign acc   = psel && penable && pready;

  // Address check and read mux
  always_comb begin
    addr_ok = 1'b1;
    rd_mux  = 32'h0000_0000;
    unique case (paddr)
      OFS_CTRL:   rd_mux = {30'h0000_0000, mode};
      OFS_PULSE:  rd_mux = {16'h0000, pulse_ms};
      OFS_EVOLVE: rd_mux = {16'h0000, evolve_ms};
      OFS_STATUS: rd_mux = {27'h0000_000, all_phases_trip_out, any_trip_out, trip_q};
      OFS_EVENT:  rd_mux = {24'h00_0000, evt_q};
      default:    addr_ok = 1'b0;  // Unmapped address
    endcase
  end

  // Answer one cycle after setup: ready, data and error from flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite) begin
        prdata <= addr_ok ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Settings written at the access edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode      <= PSTL_MODE_OFF;
      pulse_ms  <= PULSE_RST;
      evolve_ms <= EVOLVE_RST;
      tclr      <= 1'b0;
    end else begin
      tclr <= 1'b0;
      if (acc && pwrite && !pslverr) begin
        unique case (paddr)
          OFS_CTRL: begin
            // Illegal mode code falls back to off
            if (pwdata[CTRL_MODE_LSB +: 2] == 2'h3) begin
              mode <= PSTL_MODE_OFF;
            end else begin
              mode <= pstl_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            end
            tclr <= pwdata[CTRL_TCLR_BIT];
          end
          OFS_PULSE:  pulse_ms  <= clamp_ms(pwdata);
          OFS_EVOLVE: evolve_ms <= clamp_ms(pwdata);
          default: begin
          end
        endcase
      end
    end
  end

  // Millisecond tick divider
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tclr) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b0;
    end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
      tick_cnt <= 16'h0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
      tick     <= 1'b0;
    end
  end

  // Trip decision
  always_comb begin
    kill     = req_s.block_in || (mode == PSTL_MODE_OFF);
    want_all = 1'b0;
    if (req_s.three_phase_req) begin
      want_all = 1'b1;
    end
    if ($countones(req_s.phase_req) >= 2) begin
      want_all = 1'b1;
    end
    if (req_s.force_all_phases && (req_s.single_phase_req || |req_s.phase_req)) begin
      want_all = 1'b1;
    end
    if (mode == PSTL_MODE_THREE_ONLY && (req_s.single_phase_req || |req_s.phase_req)) begin
      want_all = 1'b1;
    end
    if (evolve_cnt != 17'h0_0000 && |(req_s.phase_req & ~trip_q)) begin
      want_all = 1'b1;
    end
    want = want_all ? 3'h7 : req_s.phase_req;
    if (kill) begin
      next_trip = 3'h0;
    end else if (pulse_cnt != 17'h0_0000) begin
      next_trip = trip_q | want;
    end else begin
      next_trip = want;
    end
  end

  // Trip state and registered outputs
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_q              <= 3'h0;
      phase_a_trip        <= 1'b0;
      phase_b_trip        <= 1'b0;
      phase_c_trip        <= 1'b0;
      any_trip_out        <= 1'b0;
      all_phases_trip_out <= 1'b0;
    end else begin
      trip_q              <= next_trip;
      phase_a_trip        <= next_trip[0];
      phase_b_trip        <= next_trip[1];
      phase_c_trip        <= next_trip[2];
      any_trip_out        <= |next_trip;
      all_phases_trip_out <= &next_trip;
    end
  end

  // Minimum pulse counter: reloaded when a phase newly trips
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt <= 17'h0_0000;
    end else if (tclr || kill) begin
      pulse_cnt <= 17'h0_0000;
    end else if (|(next_trip & ~trip_q)) begin
      // One extra ms covers the free-running tick phase
      pulse_cnt <= {1'b0, pulse_ms} + 17'h0_0001;
    end else if (tick && pulse_cnt != 17'h0_0000) begin
      pulse_cnt <= pulse_cnt - 17'h0_0001;
    end
  end

  // Evolving fault window opened by a single-phase trip
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evolve_cnt <= 17'h0_0000;
    end else if (tclr || kill) begin
      evolve_cnt <= 17'h0_0000;
    end else if (trip_q == 3'h0 && $countones(next_trip) == 1) begin
      evolve_cnt <= {1'b0, evolve_ms} + 17'h0_0001;
    end else if (tick && evolve_cnt != 17'h0_0000) begin
      evolve_cnt <= evolve_cnt - 17'h0_0001;
    end
  end

  // Transition events of phase and general trips
  // One driver for the whole carrier: {off general, off c,b,a, on general, on c,b,a}
  assign evt_set = {~|next_trip & |trip_q, ~next_trip & trip_q,
                    |next_trip & ~|trip_q, next_trip & ~trip_q};

  // Sticky events; a new event wins over a clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q       <= '0;
      event_pulse <= '0;
    end else begin
      event_pulse <= evt_set;
      if (acc && pwrite && paddr == OFS_EVENT) begin
        evt_q <= (evt_q & ~pstl_evt_t'(pwdata[7:0])) | evt_set;
      end else begin
        evt_q <= evt_q | evt_set;
      end
    end
  end

  // Checks on the trip behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_armed;
    !kill && !tclr;
  endsequence

  sequence s_hold_live;
    trip_q != 3'h0 && pulse_cnt != 17'h0_0000;
  endsequence

  property p_hold;
    s_armed and s_hold_live |=> trip_q != 3'h0;
  endproperty
  a_hold: assert property (p_hold) else $error("Trip dropped before pulse time");

  property p_two_phase;
    !kill && $countones(req_s.phase_req) == 2 |=> trip_q == 3'h7 ##0 all_phases_trip_out;
  endproperty
  a_two_phase: assert property (p_two_phase) else $error("Third phase not tripped");

  property p_force;
    !kill && req_s.force_all_phases && |req_s.phase_req |=> phase_a_trip && phase_b_trip && phase_c_trip;
  endproperty
  a_force: assert property (p_force) else $error("Forced trip not three-phase");

  property p_evolve;
    !kill && evolve_cnt != 17'h0_0000 && |(req_s.phase_req & ~trip_q) |=> trip_q == 3'h7;
  endproperty
  a_evolve: assert property (p_evolve) else $error("Evolving fault not three-phase");

  property p_mode_legal;
    mode inside {PSTL_MODE_OFF, PSTL_MODE_THREE_ONLY, PSTL_MODE_SINGLE_OR_THREE};
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("Illegal mode held");

  property p_off;
    mode == PSTL_MODE_OFF |=> !any_trip_out ##1 !any_trip_out || mode != PSTL_MODE_OFF;
  endproperty
  a_off: assert property (p_off) else $error("Trip while off");

  property p_block;
    req_s.block_in |=> trip_q == 3'h0 && !any_trip_out;
  endproperty
  a_block: assert property (p_block) else $error("Trip while blocked");

  property p_three_req;
    !kill && req_s.three_phase_req |=> all_phases_trip_out;
  endproperty
  a_three_req: assert property (p_three_req) else $error("Three-phase request missed");

  property p_map;
    !kill && req_s.phase_req != 3'h0 |=> (trip_q & $past(req_s.phase_req)) == $past(req_s.phase_req);
  endproperty
  a_map: assert property (p_map) else $error("Phase request not mapped");

  property p_general;
    any_trip_out == (trip_q != 3'h0) && all_phases_trip_out == (trip_q == 3'h7);
  endproperty
  a_general: assert property (p_general) else $error("General or 3ph output wrong");

  property p_event;
    $rose(any_trip_out) |-> event_pulse.on_evt[3] ##1 evt_q.on_evt[3];
  endproperty
  a_event: assert property (p_event) else $error("Trip event not reported");

  property p_three_only;
    !kill && mode == PSTL_MODE_THREE_ONLY && req_s.single_phase_req |=> trip_q == 3'h7;
  endproperty
  a_three_only: assert property (p_three_only) else $error("Three-only mode tripped one phase");

  property p_tclr;
    tclr |=> pulse_cnt == 17'h0_0000 && evolve_cnt == 17'h0_0000 && tick_cnt == 16'h0000;
  endproperty
  a_tclr: assert property (p_tclr) else $error("Timers not cleared");

endmodule

`default_nettype wire

/* verification/pstl_req_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Protection function side: presents requests on the pins just after an edge
module pstl_req_model (
  input  wire logic                core_clk,  // Core clock
  input  wire logic                rst_n,     // Async reset, active low
  input  wire pstl_pkg::pstl_req_t next_req,  // Request wanted next cycle
  output var  pstl_pkg::pstl_req_t req_in     // Request pins toward the trip logic
);
  import pstl_pkg::*;

  // Requests change only after a rising edge and hold for whole cycles
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_in <= '0;  // Nothing requested in reset
    end else begin
      req_in <= next_req;
    end
  end
endmodule

`default_nettype wire

/* verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import pstl_pkg::*;

  logic        core_clk = 1'b0;      // 50 MHz clock
  logic        rst_n;                // Reset, active low
  pstl_req_t   next_req;             // Request handed to the partner
  pstl_req_t   req_in;               // Request pins
  logic        psel;                 // APB select
  logic        penable;              // APB enable
  logic        pwrite;               // APB direction
  logic [7:0]  paddr;                // APB address
  logic [31:0] pwdata;               // APB write data
  logic [31:0] prdata;               // APB read data
  logic        pready;               // APB ready
  logic        pslverr;              // APB error
  logic [2:0]  trips;                // Phase trips {c,b,a}
  logic        any_trip_out;         // General trip
  logic        all_phases_trip_out;  // Three-phase trip
  pstl_evt_t   event_pulse;          // On/off event pulses
  logic [31:0] rd;                   // Last read data
  logic        err;                  // Last error response
  logic [31:0] seed;                 // Random state
  int          n_errors;             // Mismatch count
  int          comparisons;          // Comparison count
  int          n;                    // Cycle counter

  // Short tick so the millisecond timers fit the run
  pstl_trip_logic #(.TICK_CYCLES(10)) pstl_trip_logic_inst (
    .core_clk, .rst_n, .req_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .phase_a_trip(trips[0]), .phase_b_trip(trips[1]),
    .phase_c_trip(trips[2]), .any_trip_out, .all_phases_trip_out, .event_pulse);

  pstl_req_model pstl_req_model_inst (.core_clk, .rst_n, .next_req, .req_in);

  // Clock generator
  always #10 core_clk = ~core_clk;

  // Step of the random sequence
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Reference: settled trip vector for a request seen from idle
  function automatic logic [2:0] exp_trip(input int m, input pstl_req_t r);
    logic any_req;
    any_req = r.single_phase_req | r.three_phase_req | (|r.phase_req);
    if (r.block_in || m == 0 || m == 3) begin
      return 3'h0;
    end
    if (any_req && (m == 1 || r.three_phase_req || r.force_all_phases ||
        $countones(r.phase_req) >= 2)) begin
      return 3'h7;
    end
    return r.phase_req;
  endfunction

  // Value comparison
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Only the watchdog ends a wait that never gets an answer
    while (pready !== 1'b1) begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Apply {mode, request} from idle, check the trip and its hold
  task automatic run_case(input logic [8:0] c);
    logic [2:0] e;
    e = exp_trip(int'(c[8:7]), c[6:0]);
    apb(1'b1, OFS_CTRL, {30'h0, c[8:7]});
    @(posedge core_clk);
    next_req <= c[6:0];
    for (n = 0; n < 8 && any_trip_out !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("trips", e, trips);
    chk("general", |e, any_trip_out);
    chk("all_phases", &e, all_phases_trip_out);
    chk("on_event", (e != 0) ? {1'b1, e} : 4'h0, event_pulse.on_evt);
    @(posedge core_clk);
    next_req <= '0;
    for (n = 0; n < 700 && any_trip_out === 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (e != 0) begin
      chk("off_event", {1'b1, e}, event_pulse.off_evt);
      chk("hold_ok", 1, n >= 498 && n <= 512);
    end
    repeat (80) @(posedge core_clk);
  endtask

  // Verdict and end of run
  task test_done;
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    logic [8:0] cases [10];
    cases = '{9'h001, 9'h101, 9'h122, 9'h104, 9'h103, 9'h109, 9'h110, 9'h082, 9'h141, 9'h181};
    rst_n = 1'b0;
    next_req = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    seed = 32'h3E8E;
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    // Reset values, refused address, clamped setting
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_rst", 32'h0, rd);
    apb(1'b0, OFS_PULSE, 32'h0);
    chk("pulse_rst", PULSE_RST, rd);
    apb(1'b0, OFS_EVOLVE, 32'h0);
    chk("evolve_rst", EVOLVE_RST, rd);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 1, err);
    apb(1'b1, OFS_PULSE, 32'hA);
    apb(1'b0, OFS_PULSE, 32'h0);
    chk("pulse_clamp", MS_MIN, rd);
    apb(1'b1, OFS_EVOLVE, 32'h32);
    // Every mode and every request input
    foreach (cases[i]) run_case(cases[i]);
    apb(1'b0, OFS_EVENT, 32'h0);
    chk("events", 32'hFF, rd);
    apb(1'b1, OFS_EVENT, 32'hFF);
    apb(1'b0, OFS_EVENT, 32'h0);
    chk("events_clr", 32'h0, rd);
    // Random requests, block kept low
    repeat (6) begin
      seed = lfsr(seed);
      run_case(seed[8:0] & 9'h1BF);
    end
    // Second phase inside the evolving window, timers cleared on the mode write
    apb(1'b1, OFS_CTRL, 32'h6);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl_mode", 32'h2, rd);
    @(posedge core_clk);
    next_req <= 7'h01;
    repeat (4) @(posedge core_clk);
    next_req <= '0;
    repeat (100) @(posedge core_clk);
    next_req <= 7'h02;
    for (n = 0; n < 8 && all_phases_trip_out !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk("evolve_trip", 32'h7, trips);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", 32'h1F, rd);
    // Block in mid-trip drops everything
    @(posedge core_clk);
    next_req <= 7'h40;
    repeat (8) @(posedge core_clk);
    #1;
    chk("blocked", 32'h0, {all_phases_trip_out, any_trip_out, trips});
    @(posedge core_clk);
    next_req <= '0;
    repeat (600) @(posedge core_clk);
    test_done();
  end
endmodule

`default_nettype wire
